// ---- serial_peer.sv ----
// Serial peer that echoes the transmit line back to the receiver.
// Assumes the line idles at mark through a pull-up when unplugged.
`timescale 1ns/1ns
module serial_peer (
  // Serial line
  input  wire txd,
  input  wire plugged,
  output wire rxd
);
  assign rxd = plugged ? txd : 1'b1;
endmodule // serial_peer

// ---- testbench.sv ----
// Testbench for the line-format and modem-control block.
// Assumes a looped-back serial peer and a short bit period.
`timescale 1ns/1ns
module testbench;
  localparam BC = 8;
  reg         clk, rstn, hsel, hwrite, irq_req, plugged;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, txd, rxd, rts, dtr, host_int_o, host_int_oe;
  integer     num_errors, tests_run, k;
  logic [7:0] fm [6] = '{8'h03, 8'h1e, 8'h0b, 8'h3b, 8'h2b, 8'h0f};
  uart_line_and_modem_control #(.BIT_CYCLES(BC)) u_uart_line_and_modem_control (
    .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TXD(txd), .RXD(rxd), .RTS(rts), .DTR(dtr),
    .IRQ_REQ(irq_req), .HOST_INTERRUPT_OUT_O(host_int_o), .HOST_INTERRUPT_OUT_OE(host_int_oe));
  serial_peer u_serial_peer (.txd(txd), .plugged(plugged), .rxd(rxd));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task report_and_stop;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single-word transfer; read data lands in rd.
  task xfer(input logic [2:0] idx, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {27'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task rdchk(input logic [2:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0);
    chk("register", exp, rd);
  endtask
  // Sends c1 then c2 back to back and checks the frame of c1 up to the next start.
  task send(input logic [7:0] fmt, input logic [7:0] c1, input logic [7:0] c2);
    integer len, n, i;
    logic [7:0]  m;
    logic [15:0] exp, got;
    len = fmt[0] ? 8 : 7;
    m = fmt[0] ? 8'hff : 8'h7f;
    n = len + fmt[3] + fmt[2] + 3;
    exp = 16'h0;
    got = 16'h0;
    for (i = 0; i < len; i++) exp[1+i] = c1[i];
    if (fmt[3]) exp[1+len] = fmt[5] ? ~fmt[4] : (fmt[4] ? ^(c1 & m) : ~^(c1 & m));
    for (i = len + fmt[3] + 1; i < n - 1; i++) exp[i] = 1'b1;
    xfer(3'h3, 1'b1, {24'h0, fmt});
    xfer(3'h0, 1'b1, {24'h0, c1});
    while (txd !== 1'b0) @(posedge clk);
    xfer(3'h0, 1'b1, {24'h0, c2});
    repeat (2) @(posedge clk);
    for (i = 0; i < n; i++) begin
      got[i] = txd;
      repeat (BC) @(posedge clk);
    end
    chk("frame", {16'h0, exp}, {16'h0, got});
    repeat (BC * 14) @(posedge clk);
    rdchk(3'h2, 32'h2);
    rdchk(3'h0, {24'h0, c2 & m});
  endtask
  initial begin
    {rstn, hsel, hwrite, irq_req, haddr, hwdata, htrans} = 0;
    hsize = 3'h2;
    plugged = 1'b1;
    num_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdchk(3'h3, 32'h0);
    rdchk(3'h4, 32'h0);
    xfer(3'h4, 1'b1, 32'hff);
    rdchk(3'h4, 32'h1f);
    irq_req <= 1'b1;
    @(posedge clk);
    chk("pins", 32'hf, {rts, dtr, host_int_oe, host_int_o});
    xfer(3'h4, 1'b1, 32'h4);
    @(posedge clk);
    chk("pins", 32'h0, {rts, dtr, host_int_oe});
    xfer(3'h3, 1'b1, 32'h80);
    xfer(3'h0, 1'b1, 32'h33);
    rdchk(3'h0, 32'h33);
    xfer(3'h1, 1'b1, 32'h5a);
    rdchk(3'h1, 32'h5a);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (k = 0; k < 6; k++) send(fm[k], 8'(8'h35 + k * 8'h1b), 8'(8'hc3 ^ k));
    rdchk(3'h1, 32'h0);
    plugged <= 1'b0;
    xfer(3'h3, 1'b1, 32'h43);
    repeat (BC * 12) @(posedge clk);
    chk("txd", 32'h0, {31'h0, txd});
    rdchk(3'h2, 32'h0);
    xfer(3'h3, 1'b1, 32'h03);
    @(posedge clk);
    chk("txd", 32'h1, {31'h0, txd});
    report_and_stop;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // testbench

// ---- uart_lc_checker_assertions.sv ----
// Checker for the line-format and modem-control block, bound to its top ports.
// Assumes zero-wait AHB-Lite transfers and byte addresses of four times the index.
`timescale 1ns/1ns
module uart_lc_checker (
  // Clock and reset
  input wire        CLK,
  input wire        RSTN,
  // Register bus
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  input wire [31:0] HRDATA,
  // Pins
  input wire        TXD,
  input wire        RTS,
  input wire        DTR,
  input wire        IRQ_REQ,
  input wire        HOST_INTERRUPT_OUT_O,
  input wire        HOST_INTERRUPT_OUT_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire take = HSEL && HREADY && HTRANS[1];
  reg  wr_fmt;
  reg  wr_mc;
  reg  brk;
  // Shadow of the break bit, caught in the data phase of a format write.
  always @(posedge CLK) begin
    wr_fmt <= RSTN && take && HWRITE && HADDR == 32'hc;
    wr_mc  <= RSTN && take && HWRITE && HADDR == 32'h10;
    if (!RSTN) brk <= 1'b0;
    else if (wr_fmt) brk <= HWDATA[6];
  end
  sequence s_wmc; take && HWRITE && HADDR == 32'h10 ##1 1'b1; endsequence
  property p_rts; s_wmc |=> RTS == $past(HWDATA[1]); endproperty
  a_rts: assert property (p_rts) else $error("request-to-send wrong");
  property p_dtr; s_wmc |=> DTR == $past(HWDATA[0]); endproperty
  a_dtr: assert property (p_dtr) else $error("terminal-ready wrong");
  property p_oe; s_wmc |=> HOST_INTERRUPT_OUT_OE == $past(HWDATA[3]); endproperty
  a_oe: assert property (p_oe) else $error("interrupt enable wrong");
  property p_int_level; HOST_INTERRUPT_OUT_OE |-> HOST_INTERRUPT_OUT_O == IRQ_REQ; endproperty
  a_int_level: assert property (p_int_level) else $error("interrupt level wrong");
  property p_rdmc; take && !HWRITE && HADDR == 32'h10 |=> HRDATA[31:5] == 27'h0; endproperty
  a_rdmc: assert property (p_rdmc) else $error("unused modem bits set");
  property p_only; $changed({RTS, DTR, HOST_INTERRUPT_OUT_OE}) |-> $past(wr_mc); endproperty
  a_only: assert property (p_only) else $error("modem pin moved alone");
  property p_brk; brk |-> !TXD; endproperty
  a_brk: assert property (p_brk) else $error("break not forced");
  property p_rst; $rose(RSTN) |-> TXD && !RTS && !DTR && !HOST_INTERRUPT_OUT_OE; endproperty
  a_rst: assert property (p_rst) else $error("pins active after reset");
  cover property (s_wmc);
  cover property (brk && !TXD);
  cover property ($fell(TXD) && !brk);
endmodule // uart_lc_checker
bind uart_line_and_modem_control uart_lc_checker u_uart_lc_checker (
  .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .TXD(TXD), .RTS(RTS), .DTR(DTR),
  .IRQ_REQ(IRQ_REQ), .HOST_INTERRUPT_OUT_O(HOST_INTERRUPT_OUT_O),
  .HOST_INTERRUPT_OUT_OE(HOST_INTERRUPT_OUT_OE));

// ---- uart_lc_defs.vh ----
// Constants for the line-format and modem-control block: offsets, bits, codes.
// Assumes inclusion by plain Verilog design files only.
`ifndef UART_LC_DEFS_VH
`define UART_LC_DEFS_VH
// Register indices; byte address is four times the index.
`define IDX_RXTX        3'h0
`define IDX_IER         3'h1
`define IDX_LINE_FMT    3'h3
`define IDX_MODEM_CTL   3'h4
`define IDX_SERIAL_CTL  3'h7
`define IDX_SERIAL_STAT 3'h2
// Line format control fields.
`define LF_DIV_ACCESS   7
`define LF_BREAK        6
`define LF_STICK        5
`define LF_EVEN         4
`define LF_PAR_EN       3
`define LF_STOP         2
`define LF_LEN_HI       1
`define LF_LEN_LO       0
`define LF_RESET        8'h00
// Modem line control fields.
`define MC_INT_EN       3
`define MC_OUT1         2
`define MC_RTS          1
`define MC_DTR          0
`define MC_WMASK        8'h1f
`define MC_RESET        8'h00
// Character length codes.
`define LEN_7           2'h2
`define LEN_8           2'h3
// Serial status bits (own register).
`define SS_TX_BUSY      0
`define SS_RX_READY     1
`define SS_PAR_ERR      2
`define SS_FRAME_ERR    3
// Default bit period in clock cycles.
`define BIT_CYCLES      16'd2170
`endif

// ---- uart_lc_rx.v ----
// Serial receiver: samples mid-bit, checks parity and the first stop bit only.
// Assumes the receive input is synchronous and idles high.
`timescale 1ns/1ns
`include "uart_lc_defs.vh"
module uart_lc_rx #(
  parameter BIT_CYCLES = 2170
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       rxd,
  input  wire [7:0] fmt,
  output reg  [7:0] data,
  output reg        done,
  output reg        par_err,
  output reg        frame_err
);
  localparam S_IDLE = 4'b0001;
  localparam S_DATA = 4'b0010;
  localparam S_PAR  = 4'b0100;
  localparam S_STOP = 4'b1000;

  reg [3:0]  state;
  reg [15:0] cnt;
  reg [2:0]  bit_n;
  reg [7:0]  shift;
  reg        par;
  reg        perr;

  wire [2:0]  last_bit = fmt[`LF_LEN_LO] ? 3'h7 : 3'h6;
  wire        tick     = (cnt == 16'h0000);
  wire [15:0] period   = BIT_CYCLES[15:0] - 16'h0001;
  wire        want_par = fmt[`LF_STICK] ? ~fmt[`LF_EVEN] : (par ^ ~fmt[`LF_EVEN]);

  always @(posedge clk) begin
    if (!rstn) begin
      state     <= S_IDLE;
      cnt       <= 16'h0000;
      bit_n     <= 3'h0;
      shift     <= 8'h00;
      par       <= 1'b0;
      perr      <= 1'b0;
      data      <= 8'h00;
      done      <= 1'b0;
      par_err   <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (!rxd) begin
            cnt   <= period + {1'b0, period[15:1]};
            bit_n <= 3'h0;
            par   <= 1'b0;
            perr  <= 1'b0;
            shift <= 8'h00;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (tick) begin
            shift <= fmt[`LF_LEN_LO] ? {rxd, shift[7:1]} : {1'b0, rxd, shift[6:1]};
            par   <= par ^ rxd;
            bit_n <= bit_n + 3'h1;
            cnt   <= period;
            if (bit_n == last_bit)
              state <= fmt[`LF_PAR_EN] ? S_PAR : S_STOP;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_PAR: begin
          if (tick) begin
            perr  <= (rxd != want_par);
            cnt   <= period;
            state <= S_STOP;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_STOP: begin
          // Only the first stop bit is sampled; the receiver re-arms at once.
          if (tick) begin
            data      <= shift;
            done      <= 1'b1;
            par_err   <= perr;
            frame_err <= ~rxd;
            state     <= S_IDLE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // uart_lc_rx

// ---- uart_lc_tx.v ----
// Serial transmitter: start, 7 or 8 data bits, optional parity, stop bits.
// Assumes a one-cycle load strobe taken only while idle and a fixed bit period.
`timescale 1ns/1ns
`include "uart_lc_defs.vh"
module uart_lc_tx #(
  parameter BIT_CYCLES = 2170
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       load,
  input  wire [7:0] data,
  input  wire [7:0] fmt,
  output reg        txd,
  output wire       busy
);
  localparam S_IDLE = 4'b0001;
  localparam S_DATA = 4'b0010;
  localparam S_PAR  = 4'b0100;
  localparam S_STOP = 4'b1000;

  reg [3:0]  state;
  reg [15:0] cnt;
  reg [2:0]  bit_n;
  reg [7:0]  shift;
  reg        par;
  reg [2:0]  half_stops;

  wire [2:0] last_bit = fmt[`LF_LEN_LO] ? 3'h7 : 3'h6;
  wire       tick     = (cnt == 16'h0000);
  wire [15:0] period  = BIT_CYCLES[15:0] - 16'h0001;

  assign busy = (state != S_IDLE);

  always @(posedge clk) begin
    if (!rstn) begin
      state      <= S_IDLE;
      cnt        <= 16'h0000;
      bit_n      <= 3'h0;
      shift      <= 8'h00;
      par        <= 1'b0;
      half_stops <= 3'h0;
      txd        <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          txd <= 1'b1;
          if (load) begin
            shift <= data;
            par   <= 1'b0;
            bit_n <= 3'h0;
            cnt   <= period;
            txd   <= 1'b0;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (tick) begin
            txd   <= shift[0];
            par   <= par ^ shift[0];
            shift <= {1'b0, shift[7:1]};
            cnt   <= period;
            bit_n <= bit_n + 3'h1;
            if (bit_n == last_bit)
              state <= fmt[`LF_PAR_EN] ? S_PAR : S_STOP;
            // Stop time is counted in half bits: 2 or 4.
            half_stops <= fmt[`LF_STOP] ? 3'h4 : 3'h2;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_PAR: begin
          // Parity follows the last data bit, before the first stop bit.
          if (tick) begin
            state <= S_STOP;
            cnt   <= period;
            if (fmt[`LF_STICK])
              txd <= ~fmt[`LF_EVEN];
            else
              txd <= par ^ ~fmt[`LF_EVEN];
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_STOP: begin
          if (tick) begin
            txd   <= 1'b1;
            cnt   <= {1'b0, period[15:1]};
            if (half_stops == 3'h0)
              state <= S_IDLE;
            half_stops <= half_stops - 3'h1;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // uart_lc_tx

// ---- uart_line_and_modem_control.v ----
// Line-format and modem-control block of a UART with an AHB-Lite register slave.
// Assumes one clock, synchronous low reset and a single AHB-Lite master.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "uart_lc_defs.vh"
module uart_line_and_modem_control #(
  parameter BIT_CYCLES = `BIT_CYCLES
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RSTN,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  // Serial line
  output wire        TXD,
  input  wire        RXD,
  // Modem control outputs, active high
  output wire        RTS,
  output wire        DTR,
  // Host interrupt driver, released when not enabled
  input  wire        IRQ_REQ,
  output wire        HOST_INTERRUPT_OUT_O,
  output wire        HOST_INTERRUPT_OUT_OE
);
  reg  [7:0]  line_format_control;
  reg  [7:0]  modem_line_control;
  reg  [7:0]  int_enable;
  reg  [7:0]  divisor_low;
  reg  [7:0]  divisor_high;
  reg  [7:0]  tx_hold;
  reg         tx_pending;
  reg  [7:0]  receive_buffer;
  reg         rx_ready;
  reg         par_err;
  reg         frame_err;
  reg  [31:0] rdata;

  reg         dp_write;
  reg         dp_read;
  reg  [2:0]  dp_idx;

  wire        tx_line;
  wire        tx_busy;
  wire [7:0]  rx_data;
  wire        rx_done;
  wire        rx_par_err;
  wire        rx_frame_err;

  wire        divisor_access_select = line_format_control[`LF_DIV_ACCESS];
  wire        addr_ok = (HADDR[31:5] == 27'h0000000) && (HADDR[1:0] == 2'h0);
  wire        take = HSEL & HREADY & HTRANS[1];
  wire [2:0]  a_idx = HADDR[4:2];
  wire        rd_rbuf = dp_read && dp_idx == `IDX_RXTX && !divisor_access_select;

  function [7:0] read_mux;
    input [2:0] idx;
    input       dla;
    begin
      case (idx)
        `IDX_RXTX:        read_mux = dla ? divisor_low : receive_buffer;
        `IDX_IER:         read_mux = dla ? divisor_high : int_enable;
        `IDX_LINE_FMT:    read_mux = line_format_control;
        `IDX_MODEM_CTL:   read_mux = {3'h0, modem_line_control[4:0]};
        `IDX_SERIAL_STAT: read_mux = {4'h0, frame_err, par_err, rx_ready,
                                      tx_busy | tx_pending};
        default:          read_mux = 8'h00;
      endcase
    end
  endfunction

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata;

  // Address phase capture; every transfer finishes with one data-phase cycle.
  always @(posedge CLK) begin
    if (!RSTN) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_idx   <= 3'h0;
    end else begin
      dp_write <= take & HWRITE & addr_ok;
      dp_read  <= take & ~HWRITE & addr_ok;
      dp_idx   <= a_idx;
    end
  end

  // Read data is registered so that it stands during the data phase.
  always @(posedge CLK) begin
    if (!RSTN)
      rdata <= 32'h00000000;
    else if (take & ~HWRITE)
      rdata <= addr_ok ? {24'h000000, read_mux(a_idx, divisor_access_select)} : 32'h00000000;
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      line_format_control <= `LF_RESET;
      modem_line_control  <= `MC_RESET;
      int_enable          <= 8'h00;
      divisor_low         <= 8'h00;
      divisor_high        <= 8'h00;
      tx_hold             <= 8'h00;
      tx_pending          <= 1'b0;
    end else begin
      if (tx_pending && !tx_busy)
        tx_pending <= 1'b0;
      if (dp_write) begin
        case (dp_idx)
          `IDX_RXTX: begin
            if (divisor_access_select) begin
              divisor_low <= HWDATA[7:0];
            end else begin
              tx_hold    <= HWDATA[7:0];
              tx_pending <= 1'b1;
            end
          end
          `IDX_IER: begin
            if (divisor_access_select)
              divisor_high <= HWDATA[7:0];
            else
              int_enable <= HWDATA[7:0];
          end
          `IDX_LINE_FMT:  line_format_control <= HWDATA[7:0];
          `IDX_MODEM_CTL: modem_line_control <= HWDATA[7:0] & `MC_WMASK;
          default: ;
        endcase
      end
    end
  end

  // Receive status: a new character sets the flags, so it wins over a read clear.
  always @(posedge CLK) begin
    if (!RSTN) begin
      receive_buffer <= 8'h00;
      rx_ready       <= 1'b0;
      par_err        <= 1'b0;
      frame_err      <= 1'b0;
    end else if (rx_done) begin
      receive_buffer <= rx_data;
      rx_ready       <= 1'b1;
      par_err        <= rx_par_err;
      frame_err      <= rx_frame_err;
    end else begin
      if (rd_rbuf)
        rx_ready <= 1'b0;
      if (dp_read && dp_idx == `IDX_SERIAL_STAT) begin
        par_err   <= 1'b0;
        frame_err <= 1'b0;
      end
    end
  end

  uart_lc_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk  (CLK),
    .rstn (RSTN),
    .load (tx_pending & ~tx_busy),
    .data (tx_hold),
    .fmt  (line_format_control),
    .txd  (tx_line),
    .busy (tx_busy)
  );

  uart_lc_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .clk       (CLK),
    .rstn      (RSTN),
    .rxd       (RXD),
    .fmt       (line_format_control),
    .data      (rx_data),
    .done      (rx_done),
    .par_err   (rx_par_err),
    .frame_err (rx_frame_err)
  );

  // Break acts on the output pin only, so the receiver keeps running untouched.
  assign TXD = tx_line & ~line_format_control[`LF_BREAK];

  assign RTS = modem_line_control[`MC_RTS];
  assign DTR = modem_line_control[`MC_DTR];

  assign HOST_INTERRUPT_OUT_OE = modem_line_control[`MC_INT_EN];
  assign HOST_INTERRUPT_OUT_O  = IRQ_REQ;
endmodule // uart_line_and_modem_control
